// ===== bench/rsio_switch_model.sv
// External switches wired to the dual-channel safety inputs.
// Assumes the bench sets the wanted levels at the falling clock edge.
`timescale 1ns/1ps
module rsio_switch_model
   import rsio_pkg::*;
(
   // Wanted switch levels
   input wire rsio_in_s want,
   input wire logic split,
   // Dual-channel contacts
   output logic enabling_switch_in_a,
   output logic enabling_switch_in_b,
   output logic mode_selector_in_a,
   output logic mode_selector_in_b,
   output logic force_ctrl_enable_in_a,
   output logic force_ctrl_enable_in_b,
   output logic line_stop_in_a,
   output logic line_stop_in_b
);
   // Split makes channel b disagree, as a broken contact would
   rsio_in_s chan_b;
   assign chan_b = want ^ {4{split}};
   assign enabling_switch_in_a = want.enabling;
   assign enabling_switch_in_b = chan_b.enabling;
   assign mode_selector_in_a = want.mode_b;
   assign mode_selector_in_b = chan_b.mode_b;
   assign force_ctrl_enable_in_a = want.force_ctrl;
   assign force_ctrl_enable_in_b = chan_b.force_ctrl;
   // Stop comes from an upstream machine only, never fed back
   assign line_stop_in_a = want.line_stop;
   assign line_stop_in_b = chan_b.line_stop;
endmodule // rsio_switch_model

// ===== bench/tb_top.sv
// Self-checking bench for the robot safety I/O logic.
// Assumes the design filters inputs for DETECT_CYC edges, set short here.
`timescale 1ns/1ps
module tb_top;
   import rsio_pkg::*;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   rsio_in_s want = '0;
   logic split = 1'b0;
   logic motion_request = 1'b0;
   logic estop_request = 1'b0;
   logic estop_reset = 1'b0;
   logic reduced_request = 1'b0;
   logic system_error = 1'b0;
   logic en_a, en_b, md_a, md_b, fc_a, fc_b, ls_a, ls_b;
   logic motion_permit, force_ctrl_mode, verify_mode, seen_dec;
   rsio_out_s out_a, out_b;
   int err_total = 0;
   int cmp_count = 0;
   int cycles = 0;
   always #10 sys_clk = ~sys_clk;
   rsio_switch_model rsio_switch_model_i (.want(want), .split(split),
      .enabling_switch_in_a(en_a), .enabling_switch_in_b(en_b),
      .mode_selector_in_a(md_a), .mode_selector_in_b(md_b),
      .force_ctrl_enable_in_a(fc_a), .force_ctrl_enable_in_b(fc_b),
      .line_stop_in_a(ls_a), .line_stop_in_b(ls_b));
   rsio_safety_io #(.DETECT_CYC(4), .DECEL_CYC(3)) rsio_safety_io_i (
      .sys_clk(sys_clk), .rstn(rstn),
      .enabling_switch_in_a(en_a), .enabling_switch_in_b(en_b),
      .mode_selector_in_a(md_a), .mode_selector_in_b(md_b),
      .force_ctrl_enable_in_a(fc_a), .force_ctrl_enable_in_b(fc_b),
      .line_stop_in_a(ls_a), .line_stop_in_b(ls_b),
      .motion_request(motion_request), .estop_request(estop_request),
      .estop_reset(estop_reset), .reduced_request(reduced_request),
      .system_error(system_error), .motion_permit(motion_permit),
      .force_ctrl_mode(force_ctrl_mode), .verify_mode(verify_mode),
      .estop_open_out_a(out_a.estop_open), .estop_open_out_b(out_b.estop_open),
      .moving_out_a(out_a.moving), .moving_out_b(out_b.moving),
      .decelerating_out_a(out_a.decelerating),
      .decelerating_out_b(out_b.decelerating),
      .reduced_out_a(out_a.reduced), .reduced_out_b(out_b.reduced),
      .full_speed_out_a(out_a.full_speed), .full_speed_out_b(out_b.full_speed),
      .fault_out_a(out_a.fault), .fault_out_b(out_b.fault),
      .estop_closed_out_a(out_a.estop_closed),
      .estop_closed_out_b(out_b.estop_closed));
   task automatic step(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic chk(input logic [6:0] seen, input logic [6:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Both channels must carry the same status
   task automatic chk_out(input logic [6:0] exp);
      chk(out_a, exp);
      chk(out_b, exp);
   endtask
   task automatic give_verdict();
      $display("comparisons %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Whole run needs about 100 cycles
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 2000) begin
         err_total++;
         give_verdict();
      end
   end
   initial begin
      step(2);
      rstn = 1'b1;
      step(1);
      chk_out(7'h05);
      motion_request = 1'b1;
      step(8);
      chk_out(7'h25);
      chk({6'h00, motion_permit}, 7'h01);
      want.mode_b = 1'b1;
      step(8);
      chk({6'h00, verify_mode}, 7'h01);
      chk_out(7'h05);
      want.enabling = 1'b1;
      step(8);
      chk_out(7'h25);
      // Disagreeing channels are refused, the old values hold
      split = 1'b1;
      step(8);
      chk_out(7'h25);
      split = 1'b0;
      want.enabling = 1'b0;
      step(8);
      chk_out(7'h05);
      want.mode_b = 1'b0;
      want.force_ctrl = 1'b1;
      reduced_request = 1'b1;
      system_error = 1'b1;
      step(8);
      chk({6'h00, force_ctrl_mode}, 7'h01);
      chk_out(7'h2B);
      reduced_request = 1'b0;
      system_error = 1'b0;
      want.line_stop = 1'b1;
      seen_dec = 1'b0;
      repeat (14) begin
         step(1);
         seen_dec = seen_dec | out_a.decelerating;
      end
      chk({6'h00, seen_dec}, 7'h01);
      chk_out(7'h44);
      estop_reset = 1'b1;
      step(8);
      chk_out(7'h44);
      want.line_stop = 1'b0;
      motion_request = 1'b0;
      step(8);
      chk_out(7'h05);
      estop_reset = 1'b0;
      estop_request = 1'b1;
      step(8);
      chk_out(7'h44);
      estop_request = 1'b0;
      estop_reset = 1'b1;
      step(8);
      chk_out(7'h05);
      // Reset in mid-run drops a held stop back to the idle levels
      estop_request = 1'b1;
      step(2);
      chk_out(7'h44);
      rstn = 1'b0;
      step(2);
      chk_out(7'h05);
      estop_request = 1'b0;
      rstn = 1'b1;
      step(2);
      chk_out(7'h05);
      give_verdict();
   end
endmodule // tb_top

// ===== core/rsio_params.svh
// Timing constants and reset values for the robot safety I/O logic.
// Assumes a 50 MHz system clock; included by the top module.
`ifndef RSIO_PARAMS_SVH
`define RSIO_PARAMS_SVH
`define RSIO_CLK_HZ 50000000
`define RSIO_DETECT_MS 100
`define RSIO_INPUT_RESP_MS 1200
`define RSIO_OUTPUT_RESP_MS 1000
// Both counts truncate RSIO_CLK_HZ / 1000, exact for a 50 MHz clock
`define RSIO_DETECT_CYC ((`RSIO_CLK_HZ / 1000) * `RSIO_DETECT_MS)
`define RSIO_OUT_RESP_CYC ((`RSIO_CLK_HZ / 1000) * `RSIO_OUTPUT_RESP_MS)
`define RSIO_FILT_W 32
`define RSIO_DECEL_CYC_DEF 100
// Status word in reset: only full speed and closed estop are on
`define RSIO_OUT_RST 7'h05
`endif

// ===== core/rsio_pkg.sv
// Types shared by the robot safety I/O logic.
// Assumes rsio_params.svh is on the include path.
package rsio_pkg;
   typedef enum logic [3:0] {
      RSIO_ST_IDLE = 4'h1,
      RSIO_ST_MOVE = 4'h2,
      RSIO_ST_DECEL = 4'h4,
      RSIO_ST_ESTOP = 4'h8
   } rsio_state_e;

   typedef struct packed {
      logic enabling;
      logic mode_b;
      logic force_ctrl;
      logic line_stop;
   } rsio_in_s;

   typedef struct packed {
      logic estop_open;
      logic moving;
      logic decelerating;
      logic reduced;
      logic full_speed;
      logic fault;
      logic estop_closed;
   } rsio_out_s;
endpackage

// ===== core/rsio_safety_io.sv
// Safety input qualification, motion permission and status outputs.
// Assumes all inputs are synchronous to sys_clk; channels a and b are
// redundant copies that must agree before an input is accepted.
`timescale 1ns/1ps
`include "rsio_params.svh"

module rsio_safety_io
   import rsio_pkg::*;
#(
   parameter int DETECT_CYC = `RSIO_DETECT_CYC,
   parameter int DECEL_CYC = `RSIO_DECEL_CYC_DEF
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // Dual-channel safety inputs
   input wire logic enabling_switch_in_a,
   input wire logic enabling_switch_in_b,
   input wire logic mode_selector_in_a,
   input wire logic mode_selector_in_b,
   input wire logic force_ctrl_enable_in_a,
   input wire logic force_ctrl_enable_in_b,
   input wire logic line_stop_in_a,
   input wire logic line_stop_in_b,
   // Robot-side conditions
   input wire logic motion_request,
   input wire logic estop_request,
   input wire logic estop_reset,
   input wire logic reduced_request,
   input wire logic system_error,
   // Robot-side commands
   output logic motion_permit,
   output logic force_ctrl_mode,
   output logic verify_mode,
   // Dual-channel safety outputs
   output logic estop_open_out_a,
   output logic estop_open_out_b,
   output logic moving_out_a,
   output logic moving_out_b,
   output logic decelerating_out_a,
   output logic decelerating_out_b,
   output logic reduced_out_a,
   output logic reduced_out_b,
   output logic full_speed_out_a,
   output logic full_speed_out_b,
   output logic fault_out_a,
   output logic fault_out_b,
   output logic estop_closed_out_a,
   output logic estop_closed_out_b
);
   localparam int NIN = 4;
   localparam logic [`RSIO_FILT_W-1:0] DET_MAX =
      `RSIO_FILT_W'(DETECT_CYC - 1);
   localparam logic [`RSIO_FILT_W-1:0] DEC_MAX =
      `RSIO_FILT_W'(DECEL_CYC - 1);

   rsio_in_s raw_a;
   rsio_in_s raw_b;
   rsio_in_s qual;
   rsio_out_s stat;
   rsio_state_e state;
   rsio_state_e next_state;
   logic [`RSIO_FILT_W-1:0] dec_cnt;
   logic stop_req;
   logic go;

   assign raw_a = '{enabling_switch_in_a, mode_selector_in_a,
                    force_ctrl_enable_in_a, line_stop_in_a};
   assign raw_b = '{enabling_switch_in_b, mode_selector_in_b,
                    force_ctrl_enable_in_b, line_stop_in_b};

   // Each input changes only after both channels agree for DETECT_CYC
   // cycles; a disagreement holds the last accepted value.
   genvar gi;
   generate
      for (gi = 0; gi < NIN; gi++) begin : g_filt
         logic [`RSIO_FILT_W-1:0] cnt;
         always_ff @(posedge sys_clk) begin
            if (!rstn) begin
               cnt <= '0;
               qual[gi] <= 1'b0;
            end else if (raw_a[gi] != raw_b[gi] ||
                         raw_a[gi] == qual[gi]) begin
               cnt <= '0;
            end else if (cnt >= DET_MAX) begin
               cnt <= '0;
               qual[gi] <= raw_a[gi];
            end else begin
               cnt <= cnt + 1'b1;
            end
         end
      end
   endgenerate

   // Mode low is position A (normal), high is position B (verification)
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         verify_mode <= 1'b0;
         force_ctrl_mode <= 1'b0;
      end else begin
         verify_mode <= qual.mode_b;
         force_ctrl_mode <= qual.force_ctrl;
      end
   end

   // Fully pressed and released both read as not enabled on this pin
   assign go = motion_request &&
               (!qual.mode_b || qual.enabling);
   assign stop_req = qual.line_stop || estop_request;

   always_comb begin
      next_state = state;
      case (state)
         RSIO_ST_IDLE: begin
            if (stop_req) begin
               next_state = RSIO_ST_ESTOP;
            end else if (go) begin
               next_state = RSIO_ST_MOVE;
            end
         end
         RSIO_ST_MOVE: begin
            if (stop_req) begin
               next_state = RSIO_ST_DECEL;
            end else if (!go) begin
               next_state = RSIO_ST_IDLE;
            end
         end
         RSIO_ST_DECEL: begin
            if (dec_cnt >= DEC_MAX) begin
               next_state = RSIO_ST_ESTOP;
            end
         end
         RSIO_ST_ESTOP: begin
            // A stop held by a looped partner never releases
            if (!stop_req && estop_reset) begin
               next_state = RSIO_ST_IDLE;
            end
         end
         default: next_state = RSIO_ST_ESTOP;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         state <= RSIO_ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Category 1: drives are braked to standstill before power removal
   always_ff @(posedge sys_clk) begin
      if (!rstn || state != RSIO_ST_DECEL) begin
         dec_cnt <= '0;
      end else begin
         dec_cnt <= dec_cnt + 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         motion_permit <= 1'b0;
      end else begin
         motion_permit <= (next_state == RSIO_ST_MOVE);
      end
   end

   assign stat.estop_open = (state == RSIO_ST_ESTOP);
   assign stat.moving = (state == RSIO_ST_MOVE);
   assign stat.decelerating = (state == RSIO_ST_DECEL);
   assign stat.reduced = reduced_request;
   assign stat.full_speed = !reduced_request;
   assign stat.fault = system_error;
   assign stat.estop_closed = !stat.estop_open;

   // Both channels register the same word; one cycle meets the 1000 ms
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         {estop_open_out_a, moving_out_a, decelerating_out_a,
          reduced_out_a, full_speed_out_a, fault_out_a,
          estop_closed_out_a} <= `RSIO_OUT_RST;
         {estop_open_out_b, moving_out_b, decelerating_out_b,
          reduced_out_b, full_speed_out_b, fault_out_b,
          estop_closed_out_b} <= `RSIO_OUT_RST;
      end else begin
         {estop_open_out_a, moving_out_a, decelerating_out_a,
          reduced_out_a, full_speed_out_a, fault_out_a,
          estop_closed_out_a} <= stat;
         {estop_open_out_b, moving_out_b, decelerating_out_b,
          reduced_out_b, full_speed_out_b, fault_out_b,
          estop_closed_out_b} <= stat;
      end
   end

   AST_ESTOP_NOT: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      estop_closed_out_a == !estop_open_out_a)
      else $error("estop closed not inverse of open");
   AST_REDUCED_EXCL: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      !(reduced_out_a && full_speed_out_a))
      else $error("reduced and full speed both set");
   AST_VERIFY_GATE: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      (qual.mode_b && !qual.enabling) |=> !motion_permit)
      else $error("motion permitted without enabling");
   AST_PAUSE: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      (state == RSIO_ST_MOVE && qual.mode_b && $fell(qual.enabling)
       && !stop_req) |-> (next_state == RSIO_ST_IDLE))
      else $error("motion did not pause");
   AST_MODE: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      ##1 verify_mode == $past(qual.mode_b))
      else $error("verify mode does not follow selector");
   AST_STOP_DECEL: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      (state == RSIO_ST_MOVE && stop_req) |=> ##1 decelerating_out_a)
      else $error("decelerating output missing");
   AST_ESTOP_OUT: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      (state == RSIO_ST_ESTOP) |=> estop_open_out_a)
      else $error("estop output missing");
   AST_FAULT: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      system_error |=> fault_out_b)
      else $error("fault output missing");
   AST_LATCH: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      (state == RSIO_ST_ESTOP && stop_req) |=> (state == RSIO_ST_ESTOP))
      else $error("estop released while stop held");
endmodule // rsio_safety_io
